// *** src/efmr_pkg.sv ***
// Constants shared by the exception flag and channel selection block.
// Assumes a 32-bit AHB-Lite register bus; registers sit at four times their index.

package efmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned EFMR_EXC_W = 24;
  localparam int unsigned EFMR_LOW_W = 16;
  localparam int unsigned EFMR_BYTE_W = 8;
  localparam int unsigned EFMR_SRC_W = 7;
  localparam int unsigned EFMR_DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is the index times four
  localparam logic [5:0] EFMR_IDX_PEND_UPPER = 6'h12;
  localparam logic [5:0] EFMR_IDX_SEL_A_LOW = 6'h14;
  localparam logic [5:0] EFMR_IDX_SEL_A_MID = 6'h15;
  localparam logic [5:0] EFMR_IDX_SEL_A_HIGH = 6'h16;
  localparam logic [5:0] EFMR_IDX_SEL_B_LOW = 6'h18;
  localparam logic [5:0] EFMR_IDX_SEL_B_MID = 6'h19;
  localparam logic [5:0] EFMR_IDX_SEL_B_HIGH = 6'h1A;
  localparam logic [7:0] EFMR_ADDR_PEND_UPPER = {EFMR_IDX_PEND_UPPER, 2'b00};
  localparam logic [7:0] EFMR_ADDR_SEL_A_LOW = {EFMR_IDX_SEL_A_LOW, 2'b00};
  localparam logic [7:0] EFMR_ADDR_SEL_A_MID = {EFMR_IDX_SEL_A_MID, 2'b00};
  localparam logic [7:0] EFMR_ADDR_SEL_A_HIGH = {EFMR_IDX_SEL_A_HIGH, 2'b00};
  localparam logic [7:0] EFMR_ADDR_SEL_B_LOW = {EFMR_IDX_SEL_B_LOW, 2'b00};
  localparam logic [7:0] EFMR_ADDR_SEL_B_MID = {EFMR_IDX_SEL_B_MID, 2'b00};
  localparam logic [7:0] EFMR_ADDR_SEL_B_HIGH = {EFMR_IDX_SEL_B_HIGH, 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the upper pending byte (exception n sits at n - 16)
  localparam int unsigned EFMR_BIT_BAD_MEM_ADDR = 0;
  localparam int unsigned EFMR_BIT_ILLEGAL_USAGE = 1;
  localparam int unsigned EFMR_BIT_BAD_OPERAND = 2;
  localparam int unsigned EFMR_BIT_SERIAL_FAULT = 3;
  localparam int unsigned EFMR_BIT_SYNTH_UNLOCKED = 4;
  localparam int unsigned EFMR_BIT_RX_FRAME_CUT = 5;
  localparam int unsigned EFMR_BIT_RX_MOVE_TIMEOUT = 6;
  localparam int unsigned EFMR_BIT_UNUSED = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] EFMR_PEND_RESET = 8'h00;
  localparam logic [23:0] EFMR_SEL_RESET = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // Bus encodings
  localparam logic [1:0] EFMR_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] EFMR_HSIZE_WORD = 3'b010;
  localparam logic EFMR_HRESP_OKAY = 1'b0;

endpackage

// *** src/efmr_ahb_if.sv ***
// AHB-Lite slave front end: captures word address phases, yields strobes.
// Assumes one slave on the bus; writes take no wait state, reads take one.
`timescale 1ns/1ps

module efmr_ahb_if
  import efmr_pkg::*;
#(
  parameter int unsigned HADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus address phase
  input wire logic hsel,
  input wire logic [HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  // Data phase strobes toward the register file
  output logic wr_en,
  output logic rd_en,
  output logic [HADDR_W-1:0] acc_addr
);

  initial begin
    if (HADDR_W < 7) begin
      $error("HADDR_W too small for the register map");
    end
  end

  typedef struct packed {
    logic wr;
    logic rd;
    logic [HADDR_W-1:0] addr;
  } efmr_ahb_state_t;

  efmr_ahb_state_t s_q, s_d;
  logic accept;

  ////////////////////////////////////////////////////////////////////////////
  // Only whole-word singles act; other sizes still get OKAY but do nothing
  assign accept = hsel && hready && (htrans == EFMR_HTRANS_NONSEQ) && (hsize == EFMR_HSIZE_WORD);

  always_comb begin
    s_d = s_q;
    s_d.wr = accept && hwrite;
    s_d.rd = accept && !hwrite;
    if (accept) begin
      s_d.addr = haddr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // One wait state lets read data come from a flip-flop
  assign hreadyout = !s_q.rd;
  assign wr_en = s_q.wr;
  assign rd_en = s_q.rd;
  assign acc_addr = s_q.addr;

  ////////////////////////////////////////////////////////////////////////////
  property p_read_wait;
    @(posedge clk) disable iff (rst) (accept && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

  property p_write_no_wait;
    @(posedge clk) disable iff (rst) (accept && hwrite) |=> (hreadyout && wr_en);
  endproperty
  a_write_no_wait: assert property (p_write_no_wait) else $error("write stalled");

endmodule

// *** src/efmr_chan.sv ***
// One indication channel: selected and complementary outputs from a selection word.
// Assumes exception events are one-cycle pulses on the same clock.
`timescale 1ns/1ps

module efmr_chan
  import efmr_pkg::*;
#(
  parameter int unsigned EXC_W = EFMR_EXC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Exceptions and selection
  input wire logic [EXC_W-1:0] exc_event,
  input wire logic [EXC_W-1:0] select_word,
  // Indications
  output logic ind,
  output logic comp_ind
);

  initial begin
    if (EXC_W != EFMR_EXC_W) begin
      $error("EXC_W must match the selection word width");
    end
  end

  typedef struct packed {
    logic ind;
    logic comp_ind;
  } efmr_chan_state_t;

  efmr_chan_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.ind = |(exc_event & select_word);
    s_d.comp_ind = |(exc_event & ~select_word);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ind = s_q.ind;
  assign comp_ind = s_q.comp_ind;

  ////////////////////////////////////////////////////////////////////////////
  property p_both_quiet;
    @(posedge clk) disable iff (rst) (exc_event == '0) |=> (!ind && !comp_ind);
  endproperty
  a_both_quiet: assert property (p_both_quiet) else $error("indication without exception");

endmodule

// *** src/efmr_top.sv ***
// Exception pending flags 16..23 and channel A/B selection words, with
// selected and complementary indications per channel, behind AHB-Lite.
// Assumes exception events are one-cycle pulses from logic on clk; the pin
// multiplexer outside picks which indication drives each pin.
//
// What this block does
// - Pending bits 23..16 in fixed exception order
// - Upper pending byte resets to zero
// - Channel A word from three byte registers
// - Channel B word from three byte registers
// - Selection bit n maps exception n
// - Channel A indicates selected exceptions
// - Channel B indicates selected exceptions
// - Complementary outputs indicate masked exceptions
// - All six selection bytes reset zero
`timescale 1ns/1ps

module efmr_top
  import efmr_pkg::*;
#(
  parameter int unsigned HADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [EFMR_DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [EFMR_DATA_W-1:0] hrdata,
  // Exception events, one-cycle pulses
  input wire logic [EFMR_LOW_W-1:0] exc_low_event,
  input wire logic [EFMR_SRC_W-1:0] exc_upper_event,
  // Indications toward the pin multiplexer
  output logic chan_a_ind,
  output logic chan_a_comp_ind,
  output logic chan_b_ind,
  output logic chan_b_comp_ind
);

  initial begin
    if (HADDR_W < 7) begin
      $error("HADDR_W too small for the register map");
    end
  end

  typedef struct packed {
    logic [EFMR_BYTE_W-1:0] pend;
    logic [EFMR_EXC_W-1:0] sel_a;
    logic [EFMR_EXC_W-1:0] sel_b;
    logic [EFMR_DATA_W-1:0] rdata;
  } efmr_regs_t;

  efmr_regs_t s_q, s_d;
  logic wr_en;
  logic rd_en;
  logic [HADDR_W-1:0] acc_addr;
  logic [EFMR_BYTE_W-1:0] pend_set;
  logic [EFMR_EXC_W-1:0] exc_all;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end
  efmr_ahb_if #(
    .HADDR_W(HADDR_W)
  ) u_ahb (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .acc_addr(acc_addr)
  );

  assign hresp = EFMR_HRESP_OKAY;

  ////////////////////////////////////////////////////////////////////////////
  // Event vector: exception 23 has no source, so its flag never rises
  assign pend_set = {1'b0, exc_upper_event};
  assign exc_all = {pend_set, exc_low_event};

  function automatic logic [EFMR_DATA_W-1:0] read_word(
    input logic [HADDR_W-1:0] addr,
    input efmr_regs_t r
  );
    logic [EFMR_BYTE_W-1:0] b;
    b = '0;
    if (addr == HADDR_W'(EFMR_ADDR_PEND_UPPER)) begin
      b = r.pend;
    end else if (addr == HADDR_W'(EFMR_ADDR_SEL_A_LOW)) begin
      b = r.sel_a[7:0];
    end else if (addr == HADDR_W'(EFMR_ADDR_SEL_A_MID)) begin
      b = r.sel_a[15:8];
    end else if (addr == HADDR_W'(EFMR_ADDR_SEL_A_HIGH)) begin
      b = r.sel_a[23:16];
    end else if (addr == HADDR_W'(EFMR_ADDR_SEL_B_LOW)) begin
      b = r.sel_b[7:0];
    end else if (addr == HADDR_W'(EFMR_ADDR_SEL_B_MID)) begin
      b = r.sel_b[15:8];
    end else if (addr == HADDR_W'(EFMR_ADDR_SEL_B_HIGH)) begin
      b = r.sel_b[23:16];
    end
    return {24'h000000, b};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      if (acc_addr == HADDR_W'(EFMR_ADDR_PEND_UPPER)) begin
        s_d.pend = s_q.pend & hwdata[7:0];
      end else if (acc_addr == HADDR_W'(EFMR_ADDR_SEL_A_LOW)) begin
        s_d.sel_a[7:0] = hwdata[7:0];
      end else if (acc_addr == HADDR_W'(EFMR_ADDR_SEL_A_MID)) begin
        s_d.sel_a[15:8] = hwdata[7:0];
      end else if (acc_addr == HADDR_W'(EFMR_ADDR_SEL_A_HIGH)) begin
        s_d.sel_a[23:16] = hwdata[7:0];
      end else if (acc_addr == HADDR_W'(EFMR_ADDR_SEL_B_LOW)) begin
        s_d.sel_b[7:0] = hwdata[7:0];
      end else if (acc_addr == HADDR_W'(EFMR_ADDR_SEL_B_MID)) begin
        s_d.sel_b[15:8] = hwdata[7:0];
      end else if (acc_addr == HADDR_W'(EFMR_ADDR_SEL_B_HIGH)) begin
        s_d.sel_b[23:16] = hwdata[7:0];
      end
    end
    // Set after the clear, so an event in the clearing cycle survives
    s_d.pend = s_d.pend | pend_set;
    if (rd_en) begin
      s_d.rdata = read_word(acc_addr, s_q);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.pend <= EFMR_PEND_RESET;
      s_q.sel_a <= EFMR_SEL_RESET;
      s_q.sel_b <= EFMR_SEL_RESET;
      s_q.rdata <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Channels: registered from the same edge that sets the flags
  efmr_chan #(
    .EXC_W(EFMR_EXC_W)
  ) u_chan_a (
    .clk(clk),
    .rst(rst),
    .exc_event(exc_all),
    .select_word(s_q.sel_a),
    .ind(chan_a_ind),
    .comp_ind(chan_a_comp_ind)
  );

  efmr_chan #(
    .EXC_W(EFMR_EXC_W)
  ) u_chan_b (
    .clk(clk),
    .rst(rst),
    .exc_event(exc_all),
    .select_word(s_q.sel_b),
    .ind(chan_b_ind),
    .comp_ind(chan_b_comp_ind)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic pend_wr;
  assign pend_wr = wr_en && (acc_addr == HADDR_W'(EFMR_ADDR_PEND_UPPER));

  property p_unused_low;
    @(posedge clk) disable iff (rst) s_q.pend[EFMR_BIT_UNUSED] == 1'b0;
  endproperty
  a_unused_low: assert property (p_unused_low) else $error("unused flag set");

  property p_event_sets;
    @(posedge clk) disable iff (rst)
      (exc_upper_event != '0) |=>
        ((s_q.pend[6:0] & $past(exc_upper_event)) == $past(exc_upper_event));
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event flag not set");

  property p_pend_reset;
    @(posedge clk) $past(rst) |-> (s_q.pend == EFMR_PEND_RESET);
  endproperty
  a_pend_reset: assert property (p_pend_reset) else $error("flags not zero after reset");

  property p_sel_reset;
    @(posedge clk) $past(rst) |-> (s_q.sel_a == EFMR_SEL_RESET && s_q.sel_b == EFMR_SEL_RESET);
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("select not zero after reset");

  property p_write_clears;
    @(posedge clk) disable iff (rst)
      (pend_wr && exc_upper_event == '0) |=> (s_q.pend == ($past(s_q.pend) & $past(hwdata[7:0])));
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("flag clear wrong");

  property p_flags_hold;
    @(posedge clk) disable iff (rst)
      (!pend_wr && exc_upper_event == '0) |=> $stable(s_q.pend);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flag changed alone");

  property p_sel_a_high;
    @(posedge clk) disable iff (rst)
      (wr_en && acc_addr == HADDR_W'(EFMR_ADDR_SEL_A_HIGH)) |=>
        (s_q.sel_a[23:16] == $past(hwdata[7:0]) && $stable(s_q.sel_a[15:0]));
  endproperty
  a_sel_a_high: assert property (p_sel_a_high) else $error("select A high byte wrong");

  property p_sel_b_mid;
    @(posedge clk) disable iff (rst)
      (wr_en && acc_addr == HADDR_W'(EFMR_ADDR_SEL_B_MID)) |=>
        (s_q.sel_b[15:8] == $past(hwdata[7:0]) && $stable(s_q.sel_a));
  endproperty
  a_sel_b_mid: assert property (p_sel_b_mid) else $error("select B mid byte wrong");

  property p_ind_a;
    @(posedge clk) disable iff (rst) (|(exc_all & s_q.sel_a)) |=> chan_a_ind;
  endproperty
  a_ind_a: assert property (p_ind_a) else $error("channel A missed exception");

  property p_ind_b;
    @(posedge clk) disable iff (rst) (|(exc_all & s_q.sel_b)) == 1'b0 |=> !chan_b_ind;
  endproperty
  a_ind_b: assert property (p_ind_b) else $error("channel B spurious indication");

  property p_comp_a;
    @(posedge clk) disable iff (rst) (|(exc_all & ~s_q.sel_a)) |=> chan_a_comp_ind;
  endproperty
  a_comp_a: assert property (p_comp_a) else $error("complement A missed masked exception");

  property p_flag_with_ind;
    @(posedge clk) disable iff (rst)
      (exc_upper_event[EFMR_BIT_RX_FRAME_CUT] && s_q.sel_b[21]) |=>
        (s_q.pend[EFMR_BIT_RX_FRAME_CUT] && chan_b_ind);
  endproperty
  a_flag_with_ind: assert property (p_flag_with_ind) else $error("indication late");

  property p_read_pend;
    @(posedge clk) disable iff (rst)
      (rd_en && acc_addr == HADDR_W'(EFMR_ADDR_PEND_UPPER)) |=>
        (hrdata == {24'h000000, $past(s_q.pend)} && hreadyout);
  endproperty
  a_read_pend: assert property (p_read_pend) else $error("flag read wrong");

  property p_ind_b_hit;
    @(posedge clk) disable iff (rst) (|(exc_all & s_q.sel_b)) |=> chan_b_ind;
  endproperty
  a_ind_b_hit: assert property (p_ind_b_hit) else $error("channel B missed exception");

  property p_comp_b;
    @(posedge clk) disable iff (rst) (|(exc_all & ~s_q.sel_b)) |=> chan_b_comp_ind;
  endproperty
  a_comp_b: assert property (p_comp_b) else $error("complement B missed exception");

  property p_ind_a_quiet;
    @(posedge clk) disable iff (rst) (|(exc_all & s_q.sel_a)) == 1'b0 |=> !chan_a_ind;
  endproperty
  a_ind_a_quiet: assert property (p_ind_a_quiet) else $error("channel A spurious");

  property p_comp_a_quiet;
    @(posedge clk) disable iff (rst) (|(exc_all & ~s_q.sel_a)) == 1'b0 |=> !chan_a_comp_ind;
  endproperty
  a_comp_a_quiet: assert property (p_comp_a_quiet) else $error("complement A spurious");

  property p_write_one_keeps;
    @(posedge clk) disable iff (rst)
      (pend_wr && hwdata[7:0] == 8'hFF) |=> (s_q.pend == ($past(s_q.pend) | $past(pend_set)));
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps) else $error("flag moved");

  property p_sel_a_low;
    @(posedge clk) disable iff (rst)
      (wr_en && acc_addr == HADDR_W'(EFMR_ADDR_SEL_A_LOW)) |=>
        (s_q.sel_a[7:0] == $past(hwdata[7:0]) && $stable(s_q.sel_b));
  endproperty
  a_sel_a_low: assert property (p_sel_a_low) else $error("select A low byte wrong");

  c_clear_race: cover property (@(posedge clk) disable iff (rst)
    pend_wr && (exc_upper_event & ~hwdata[6:0]) != '0);
  c_comp_b: cover property (@(posedge clk) disable iff (rst) chan_b_comp_ind);
  c_both_a: cover property (@(posedge clk) disable iff (rst) chan_a_ind && chan_a_comp_ind);
  c_read_sel: cover property (@(posedge clk) disable iff (rst)
    rd_en && acc_addr == HADDR_W'(EFMR_ADDR_SEL_B_HIGH));

endmodule

// *** verif/efmr_pin_watch.sv ***
// Host side model: watches the four indication lines and counts high cycles.
// Assumes indications are registered on clk and sampled at its rising edge.
`timescale 1ns/1ps

module efmr_pin_watch (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Indication lines
  input wire logic [3:0] ind,
  // Counts seen per line
  output logic [3:0][15:0] cnt
);
  // One count per high cycle, since each event cycle gives one cycle of level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        cnt[i] <= cnt[i] + 16'(ind[i] === 1'b1);
      end
    end
  end
endmodule

// *** verif/test_exception_flag_mask_routing.sv ***
// Self-checking bench for the exception flag and channel selection block.
// Assumes one AHB-Lite slave, so hready is the slave's own hreadyout.
`timescale 1ns/1ps

module test_exception_flag_mask_routing;
  import efmr_pkg::*;

  logic clk, rst, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] exc_lo;
  logic [6:0] exc_up;
  logic [6:0] race_up;
  logic [2:0] bus_size;
  logic a_ind, a_cmp, b_ind, b_cmp;
  logic [3:0][15:0] cnt, exp_cnt;
  logic [23:0] sel_a, sel_b;
  logic [7:0] pend;
  logic [7:0] sel_addr [6];
  int err_count, n_compared;

  efmr_top #(.HADDR_W(8)) dut_u (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .exc_low_event(exc_lo), .exc_upper_event(exc_up),
    .chan_a_ind(a_ind), .chan_a_comp_ind(a_cmp),
    .chan_b_ind(b_ind), .chan_b_comp_ind(b_cmp)
  );

  efmr_pin_watch host_u (
    .clk(clk), .rst(rst), .ind({b_cmp, b_ind, a_cmp, a_ind}), .cnt(cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [3:0] exp_ind(input logic [23:0] ev);
    return {|(ev & ~sel_b), |(ev & sel_b), |(ev & ~sel_a), |(ev & sel_a)};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Bounded wait for hready high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_count++;
      test_done();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= EFMR_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= bus_size;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    // Optional event that stands exactly in the data phase
    if (race_up != 7'h00) begin
      exc_up <= race_up;
    end
    wait_ready();
    if (race_up != 7'h00) begin
      exc_up <= 7'h00;
    end
    rd = hrdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, $urandom);
    check(what, rd, {24'h000000, exp});
    check("hresp", hresp, EFMR_HRESP_OKAY);
  endtask

  // One event cycle; indications are looked at in the cycle after it
  task automatic pulse(input logic [15:0] lo, input logic [6:0] up);
    logic [23:0] ev;
    logic [3:0] e;
    ev = {1'b0, up, lo};
    e = exp_ind(ev);
    exc_lo <= lo;
    exc_up <= up;
    @(posedge clk);
    exc_lo <= 16'h0000;
    exc_up <= 7'h00;
    pend = pend | {1'b0, up};
    for (int j = 0; j < 4; j++) begin
      exp_cnt[j] = exp_cnt[j] + 16'(e[j]);
    end
    #1;
    check("chan_a_ind", a_ind, e[0]);
    check("chan_b_ind", b_ind, e[2]);
    check("comp_ind", {b_cmp, a_cmp}, {e[3], e[1]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {hsel, hwrite} = 2'b00;
    haddr = 8'h00;
    htrans = 2'b00;
    hsize = EFMR_HSIZE_WORD;
    race_up = 7'h00;
    bus_size = EFMR_HSIZE_WORD;
    hwdata = 32'h00000000;
    {exc_lo, exc_up} = '0;
    {sel_a, sel_b, pend, exp_cnt} = '0;
    {err_count, n_compared} = 0;
    sel_addr = '{EFMR_ADDR_SEL_A_LOW, EFMR_ADDR_SEL_A_MID, EFMR_ADDR_SEL_A_HIGH,
                 EFMR_ADDR_SEL_B_LOW, EFMR_ADDR_SEL_B_MID, EFMR_ADDR_SEL_B_HIGH};
    void'($urandom(32'h83CF47E2));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("pend reset", EFMR_ADDR_PEND_UPPER, EFMR_PEND_RESET);
    for (int i = 0; i < 6; i++) begin
      rd_chk("sel reset", sel_addr[i], 8'h00);
    end
    rd_chk("unmapped", 8'h4C, 8'h00);
    $display("test reset values done");
    // Each upper exception alone, then write one and write zero
    for (int i = 0; i < 7; i++) begin
      pulse(16'h0000, 7'(1 << i));
      rd_chk("pend order", EFMR_ADDR_PEND_UPPER, 8'(1 << i));
      bus(1'b1, EFMR_ADDR_PEND_UPPER, 32'h000000FF);
      rd_chk("pend write one", EFMR_ADDR_PEND_UPPER, 8'(1 << i));
      bus(1'b1, EFMR_ADDR_PEND_UPPER, 32'h00000000);
      rd_chk("pend write zero", EFMR_ADDR_PEND_UPPER, 8'h00);
      pend = 8'h00;
    end
    $display("test flag order done");
    // Random selection words, all-ones and zero among them; upper data bits junk
    for (int r = 0; r < 6; r++) begin
      sel_a = (r == 0) ? 24'hFFFFFF : 24'($urandom);
      sel_b = (r == 0) ? 24'h000000 : 24'($urandom);
      for (int i = 0; i < 3; i++) begin
        bus(1'b1, sel_addr[i], {24'($urandom), sel_a[8*i +: 8]});
        bus(1'b1, sel_addr[i+3], {24'($urandom), sel_b[8*i +: 8]});
      end
      for (int i = 0; i < 3; i++) begin
        rd_chk("sel a", sel_addr[i], sel_a[8*i +: 8]);
        rd_chk("sel b", sel_addr[i+3], sel_b[8*i +: 8]);
      end
      for (int k = 0; k < 40; k++) begin
        pulse(16'(1 << ($urandom % 20)), 7'(1 << ($urandom % 10)));
      end
      rd_chk("pend accum", EFMR_ADDR_PEND_UPPER, pend);
      bus(1'b1, EFMR_ADDR_PEND_UPPER, 32'h00000000);
      pend = 8'h00;
    end
    $display("test random routing done");
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      check("pin count", {16'h0000, cnt[i]}, {16'h0000, exp_cnt[i]});
    end
    $display("test pin counts done");
    // Clear and event in one cycle: the event's flag must survive
    pulse(16'h0000, 7'h41);
    race_up = 7'h06;
    bus(1'b1, EFMR_ADDR_PEND_UPPER, 32'h00000000);
    race_up = 7'h00;
    rd_chk("pend race", EFMR_ADDR_PEND_UPPER, 8'h06);
    // A byte-sized write still gets OKAY but is ignored and leaves the register alone
    bus_size = 3'b000;
    bus(1'b1, sel_addr[0], 32'h000000A5);
    bus_size = EFMR_HSIZE_WORD;
    rd_chk("byte write ignored", sel_addr[0], sel_a[7:0]);
    $display("test corner cases done");
    // Reset again in mid-run, with flags and selections non-zero
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("ind after reset", {b_cmp, b_ind, a_cmp, a_ind}, 4'h0);
    rd_chk("pend reset again", EFMR_ADDR_PEND_UPPER, EFMR_PEND_RESET);
    for (int i = 0; i < 6; i++) begin
      rd_chk("sel reset again", sel_addr[i], 8'h00);
    end
    $display("test second reset done");
    test_done();
  end
endmodule
